// ===== hw/four_bit_jk_shift_register.v
// Contract
// - master clear empties all four stages at once
// - stages change only on rising clock edge, except the asynchronous clear
// - load low copies parallel inputs on edge
// - load high shifts contents one stage right
// - J,Kn both low clears; both high sets
// - J low, Kn high holds first stage
// - J high, Kn low toggles first stage
// - serial pair acts only in shift, uncleared
`timescale 1ns/1ps
`include "shift_reg_consts.vh"

module four_bit_jk_shift_register #(
    parameter BUF_DEPTH = `BUF_DEPTH,
    parameter BUF_AW = `BUF_ADDR_W
) (
    // clock and resets
    input wire sys_clk,
    input wire resetn,
    input wire master_clear_n,
    // operation request, one per shift clock
    input wire op_valid,
    output wire op_ready,
    input wire parallel_load_n,
    input wire serial_j,
    input wire serial_k_n,
    input wire parallel_in_bit0,
    input wire parallel_in_bit1,
    input wire parallel_in_bit2,
    input wire parallel_in_bit3,
    // stage outputs
    output wire stage0_out,
    output wire stage1_out,
    output wire stage2_out,
    output wire stage3_out,
    output wire stage3_out_n,
    // stream of register contents after each operation
    output wire word_valid,
    input wire word_ready,
    output wire [`SR_WIDTH-1:0] word_data
);

    reg [`SR_WIDTH-1:0] stage_ff;
    reg [`SR_WIDTH-1:0] nxt_stage;
    reg [`SR_WIDTH-1:0] stage3_n_ff;
    wire [`SR_WIDTH-1:0] parallel_in;
    wire [`SR_WIDTH-1:0] shifted;
    wire first_next;
    wire clear_n;
    wire buf_in_ready;
    wire op_take;

    // the pin clear and the system reset empty the stages the same way
    assign clear_n = resetn & master_clear_n;

    assign parallel_in = {parallel_in_bit3, parallel_in_bit2, parallel_in_bit1,
                          parallel_in_bit0};

    // an operation stalls while the buffer is full, so no word is dropped;
    // during master clear no operation is taken
    assign op_ready = buf_in_ready & master_clear_n;
    assign op_take = op_valid & op_ready;

    jk_first_stage u_first (
        .serial_j(serial_j),
        .serial_k_n(serial_k_n),
        .present(stage_ff[0]),
        .next_value(first_next)
    );

    assign shifted[0] = first_next;

    genvar g;
    generate
        for (g = 1; g < `SR_WIDTH; g = g + 1) begin : g_shift
            assign shifted[g] = stage_ff[g-1];
        end
    endgenerate

    always @* begin
        nxt_stage = stage_ff;
        if (op_take) begin
            case (parallel_load_n)
                `MODE_LOAD: nxt_stage = parallel_in;
                `MODE_SHIFT: nxt_stage = shifted;
                default: nxt_stage = stage_ff;
            endcase
        end
    end

    // complement kept in its own flop so both last-stage outputs are registered
    always @(posedge sys_clk or negedge clear_n) begin
        if (!clear_n) begin
            stage_ff <= `SR_STAGES_RESET;
            stage3_n_ff <= ~`SR_STAGES_RESET;
        end else begin
            stage_ff <= nxt_stage;
            stage3_n_ff <= ~nxt_stage;
        end
    end

    assign stage0_out = stage_ff[0];
    assign stage1_out = stage_ff[1];
    assign stage2_out = stage_ff[2];
    assign stage3_out = stage_ff[3];
    assign stage3_out_n = stage3_n_ff[3];

    // direction select belongs to the outside wiring of two such
    // registers; this block only ever shifts toward the last stage

    two_entry_buffer #(
        .WIDTH(`SR_WIDTH),
        .DEPTH(BUF_DEPTH),
        .AW(BUF_AW)
    ) u_buf (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(op_take),
        .in_ready(buf_in_ready),
        .in_data(nxt_stage),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );

endmodule // four_bit_jk_shift_register

// ===== hw/shift_reg_consts.vh
`ifndef SHIFT_REG_CONSTS_VH
`define SHIFT_REG_CONSTS_VH

// register geometry
`define SR_WIDTH 4
`define SR_STAGES_RESET 4'h0

// parallel_load_n levels
`define MODE_LOAD 1'b0
`define MODE_SHIFT 1'b1

// {serial_j, serial_k_n} codes for the first stage
`define JK_CLEAR 2'b00
`define JK_HOLD 2'b01
`define JK_TOGGLE 2'b10
`define JK_SET 2'b11

// output buffer geometry
`define BUF_DEPTH 2
`define BUF_ADDR_W 1

`endif

// ===== hw/jk_first_stage.v
`timescale 1ns/1ps
`include "shift_reg_consts.vh"

module jk_first_stage (
    // serial pair and present value
    input wire serial_j,
    input wire serial_k_n,
    input wire present,
    // value for the next edge
    output wire next_value
);

    function jk_next;
        input j;
        input k_n;
        input q;
        begin
            case ({j, k_n})
                `JK_CLEAR: jk_next = 1'b0;
                `JK_HOLD: jk_next = q;
                `JK_TOGGLE: jk_next = ~q;
                `JK_SET: jk_next = 1'b1;
                default: jk_next = q;
            endcase
        end
    endfunction

    assign next_value = jk_next(serial_j, serial_k_n, present);

endmodule // jk_first_stage

// ===== hw/two_entry_buffer.v
`timescale 1ns/1ps
`include "shift_reg_consts.vh"

module two_entry_buffer #(
    parameter WIDTH = `SR_WIDTH,
    parameter DEPTH = `BUF_DEPTH,
    parameter AW = `BUF_ADDR_W
) (
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    localparam [AW:0] FULL_COUNT = DEPTH;

    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    wire push;
    wire pop;
    integer i;

    assign in_ready = (count_ff != FULL_COUNT);
    assign out_valid = (count_ff != {(AW+1){1'b0}});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_ff[rd_ptr_ff];

    // depth must be a power of two so the pointers wrap by themselves
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_ff[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem_ff[wr_ptr_ff] <= in_data;
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule // two_entry_buffer

// ===== sim/shift_reg_monitor.sv
`timescale 1ns/1ps
module shift_reg_monitor (
    input wire sys_clk, resetn, master_clear_n, op_valid, op_ready, parallel_load_n,
    input wire serial_j, serial_k_n, parallel_in_bit0, parallel_in_bit1, parallel_in_bit2,
    input wire parallel_in_bit3, stage0_out, stage1_out, stage2_out, stage3_out, stage3_out_n,
    input wire word_valid, word_ready, input wire [3:0] word_data
);
    wire [3:0] q = {stage3_out, stage2_out, stage1_out, stage0_out};
    wire [3:0] p = {parallel_in_bit3, parallel_in_bit2, parallel_in_bit1, parallel_in_bit0};
    wire tk = op_valid && op_ready;
    wire sh = tk && parallel_load_n;
    wire mc = master_clear_n;
    wire j = serial_j;
    wire kn = serial_k_n;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    chk_clear_all: assert property (!mc |-> !q && !op_ready) else $error("clr");
    chk_idle_hold: assert property (!tk |=> !mc || q == $past(q)) else $error("hold");
    chk_load_copy: assert property (tk && !parallel_load_n |=> !mc || q == $past(p))
        else $error("load");
    chk_shift_up: assert property (sh |=> !mc || q[3:1] == $past(q[2:0]))
        else $error("sh");
    chk_jk_force: assert property (sh && j == kn |=> !mc || q[0] == $past(j))
        else $error("f");
    chk_jk_hold: assert property (sh && !j && kn |=> !mc || q[0] == $past(q[0]))
        else $error("k");
    chk_jk_flip: assert property (sh && j && !kn |=> !mc || q[0] != $past(q[0]))
        else $error("t");
    chk_last_pair: assert property (stage3_out_n != stage3_out) else $error("n");
endmodule // shift_reg_monitor

bind four_bit_jk_shift_register shift_reg_monitor mon (.*);

// ===== sim/word_sink.sv
`timescale 1ns/1ps
module word_sink (
    input wire sys_clk, stall, word_valid,
    input wire [3:0] word_data,
    output wire word_ready,
    output reg got,
    output reg [3:0] got_data
);
    assign word_ready = !stall;
    always @(posedge sys_clk) begin
        got <= word_valid && word_ready;
        got_data <= word_data;
    end
endmodule // word_sink

// ===== sim/four_bit_jk_shift_register_bench.sv
`timescale 1ns/1ps
module four_bit_jk_shift_register_bench;
    reg sys_clk = 0, resetn = 0, mc = 1, ov = 0, pl = 0, j = 0, kn = 0, stall = 0;
    reg [3:0] p = 4'h0, m = 4'h0;
    reg [31:0] x = 32'h060E0582;
    integer error_cnt = 0, checks = 0, i;
    logic [3:0] exp_q[$];
    wire rdy, wv, wr, got, s0, s1, s2, s3, s3n;
    wire [3:0] wd, gd;
    always #50 sys_clk = ~sys_clk;
    four_bit_jk_shift_register dut (.sys_clk(sys_clk), .resetn(resetn), .master_clear_n(mc),
        .op_valid(ov), .op_ready(rdy), .parallel_load_n(pl), .serial_j(j), .serial_k_n(kn),
        .parallel_in_bit0(p[0]), .parallel_in_bit1(p[1]), .parallel_in_bit2(p[2]),
        .parallel_in_bit3(p[3]), .stage0_out(s0), .stage1_out(s1), .stage2_out(s2),
        .stage3_out(s3), .stage3_out_n(s3n), .word_valid(wv), .word_ready(wr), .word_data(wd));
    word_sink sink (.sys_clk(sys_clk), .stall(stall), .word_valid(wv), .word_data(wd),
        .word_ready(wr), .got(got), .got_data(gd));
    function [31:0] xs(input [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        xs = v ^ (v << 5);
    endfunction
    // first stage: 00 clear, 01 hold, 10 toggle, 11 set
    function [3:0] nxt(input [3:0] q);
        nxt = pl ? {q[2:0], (j & ~q[0]) | (kn & q[0])} : p;
    endfunction
    task chk(input [3:0] seen, input [3:0] want);
        checks = checks + 1;
        if (seen !== want) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge sys_clk);
        resetn = 1;
        for (i = 0; i < 600; i = i + 1) begin
            @(negedge sys_clk);
            if (got) chk(gd, exp_q.pop_front());
            chk({s3, s2, s1, s0}, m);
            chk({3'h0, s3n}, {3'h0, ~m[3]});
            chk({3'h0, wv}, {3'h0, exp_q.size() != 0});
            x = xs(x);
            // a lone register is always wired for the right shift
            {ov, pl, j, kn, p} = x[7:0];
            // two-cycle clear lands with words still buffered
            mc = (i % 97) < 95;
            // long stalls first so the buffer refuses, then mostly draining
            stall = (i < 300) ? x[9] | x[10] : x[9] & x[10];
            #1;
            chk({3'h0, rdy}, {3'h0, mc && exp_q.size() < 2});
            if (!mc) m = 4'h0;
            else if (ov && rdy) begin
                m = nxt(m);
                exp_q.push_back(m);
            end
        end
        report_and_stop;
    end
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        report_and_stop;
    end
endmodule // four_bit_jk_shift_register_bench
